// file: locmd_pkg.sv
// Package for the LIN OTP-write and sleep command decoder
// Assumes a byte-level LIN receiver upstream that frames identifier, data and checksum
package locmd_pkg;
  // Protected identifiers of the two frames
  localparam logic [7:0] PID_OTP = 8'hE7;
  localparam logic [7:0] PID_SLEEP = 8'h3C;
  // Data lengths in bytes
  localparam logic [3:0] LEN_OTP = 4'h4;
  localparam logic [3:0] LEN_SLEEP = 4'h8;
  // Field values
  localparam logic [7:0] BYTE_FF = 8'hFF;
  localparam logic [7:0] BYTE_00 = 8'h00;
  localparam logic [1:0] ADDR_TOP = 2'h3;
  localparam logic [3:0] PTR_TOP = 4'hF;
  localparam int ADDR_W = 6;
  localparam int PTR_W = 4;
  // Data byte indices
  localparam logic [3:0] IDX_ADDR = 4'h0;
  localparam logic [3:0] IDX_FF = 4'h1;
  localparam logic [3:0] IDX_PTR = 4'h2;
  localparam logic [3:0] IDX_VAL = 4'h3;
  // Decoder states
  typedef enum logic [1:0] {LOCMD_IDLE, LOCMD_DATA, LOCMD_CSUM} locmd_state_t;
endpackage

// file: locmd_byte_if.sv
// Interface carrying received LIN bytes between the framer and the checker
// Assumes one clock domain shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface locmd_byte_if;
  logic [7:0] data;
  logic valid;
  logic [7:0] sum;
  logic clear;
  modport src (output data, output valid, output clear, input sum);
  modport acc (input data, input valid, input clear, output sum);
endinterface
`default_nettype wire

// file: locmd_csum.sv
// Classic LIN checksum accumulator: 8-bit add with carry wrap
// Assumes bytes arrive one per valid pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module locmd_csum (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Byte stream
  locmd_byte_if.acc bus
);
  logic [7:0] sum;
  logic [7:0] next_sum;
  logic [8:0] wide;

  // Add with end-around carry, clear starts a new frame
  always_comb begin
    wide = {1'b0, sum} + {1'b0, bus.data};
    next_sum = sum;
    if (bus.clear) begin
      next_sum = 8'h00;
    end else if (bus.valid) begin
      next_sum = wide[7:0] + {7'h00, wide[8]};
    end
  end

  // Register the running sum
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sum <= 8'h00;
    end else begin
      sum <= next_sum;
    end
  end

  assign bus.sum = sum;
endmodule
`default_nettype wire

// file: locmd_top.sv
// Decoder for the OTP byte-programming frame and the go-to-sleep frame
// Assumes a LIN byte receiver on ref_clk_i giving pid, data and checksum bytes in order
// Functional notes
// - A valid OTP frame writes exactly one OTP byte at the frame's pointer.
// - Third data byte: upper nibble all ones, low nibble is pointer; fourth is value.
// - Classic checksum over data bytes; mismatching frames are rejected.
// - Sleep frame puts the device into sleep mode.
// - Sleep needs first data byte 0x00 and seven bytes 0xFF.
`timescale 1ns/1ps
`default_nettype none
module locmd_top (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Received LIN bytes
  input wire logic pid_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_valid_i,
  input wire logic frame_abort_i,
  // Node configuration
  input wire logic [5:0] node_addr_i,
  // OTP write port
  output logic otp_wr_o,
  output logic [3:0] otp_addr_o,
  output logic [7:0] otp_data_o,
  // Sleep and status
  output logic sleep_o,
  output logic csum_err_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Frame tracking state

  // Where the decoder stands within a frame
  locmd_pkg::locmd_state_t state;
  locmd_pkg::locmd_state_t next_state;
  // Kind of frame being decoded, high for the sleep frame
  logic is_sleep;
  logic next_is_sleep;
  // Count of data bytes taken so far in this frame
  logic [3:0] idx;
  logic [3:0] next_idx;
  // Stays high while every fixed field has matched
  logic fields_ok;
  logic next_fields_ok;
  // Pointer and value held until the checksum proves the frame
  logic [3:0] ptr;
  logic [3:0] next_ptr;
  logic [7:0] val;
  logic [7:0] next_val;

  // Output registers
  logic otp_wr;
  logic next_otp_wr;
  logic [3:0] otp_addr;
  logic [3:0] next_otp_addr;
  logic [7:0] otp_data;
  logic [7:0] next_otp_data;
  logic sleep;
  logic next_sleep;
  logic csum_err;
  logic next_csum_err;

  // Running checksum of the data bytes seen so far
  logic [7:0] run_sum;

  //////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Number of data bytes that each frame kind carries
  function automatic logic [3:0] frame_len(input logic slp);
    logic [3:0] len;
    len = slp ? locmd_pkg::LEN_SLEEP : locmd_pkg::LEN_OTP;
    return len;
  endfunction

  // Checks one data byte against the fixed fields of its frame
  function automatic logic field_ok(input logic slp, input logic [3:0] i, input logic [7:0] b,
    input logic [5:0] node);
    logic ok;
    ok = 1'b1;
    if (slp) begin
      // First byte zero, all others all ones
      if (i == locmd_pkg::IDX_ADDR) begin
        ok = (b == locmd_pkg::BYTE_00);
      end else begin
        ok = (b == locmd_pkg::BYTE_FF);
      end
    end else begin
      case (i)
        locmd_pkg::IDX_ADDR: begin
          ok = (b[7:locmd_pkg::ADDR_W] == locmd_pkg::ADDR_TOP) && (b[locmd_pkg::ADDR_W-1:0] == node);
        end
        locmd_pkg::IDX_FF: begin
          ok = (b == locmd_pkg::BYTE_FF);
        end
        locmd_pkg::IDX_PTR: begin
          ok = (b[7:locmd_pkg::PTR_W] == locmd_pkg::PTR_TOP);
        end
        default: begin
          ok = 1'b1;
        end
      endcase
    end
    return ok;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Checksum accumulator

  // Only data bytes are summed; a new identifier or an abort restarts the sum
  locmd_byte_if bif ();
  assign bif.data = rx_byte_i;
  assign bif.valid = rx_valid_i && !pid_valid_i && (state == locmd_pkg::LOCMD_DATA);
  assign bif.clear = pid_valid_i || frame_abort_i;
  assign run_sum = bif.sum;

  locmd_csum u_locmd_csum (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .bus(bif.acc)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Frame decoder

  // Next values of the frame state and the outputs
  always_comb begin
    next_state = state;
    next_is_sleep = is_sleep;
    next_idx = idx;
    next_fields_ok = fields_ok;
    next_ptr = ptr;
    next_val = val;
    next_otp_wr = 1'b0;
    next_otp_addr = otp_addr;
    next_otp_data = otp_data;
    next_sleep = sleep;
    next_csum_err = 1'b0;
    if (frame_abort_i) begin
      // A cut frame is dropped without effect
      next_state = locmd_pkg::LOCMD_IDLE;
    end else if (pid_valid_i) begin
      next_idx = 4'h0;
      next_fields_ok = 1'b1;
      if (rx_byte_i == locmd_pkg::PID_OTP) begin
        next_state = locmd_pkg::LOCMD_DATA;
        next_is_sleep = 1'b0;
      end else if (rx_byte_i == locmd_pkg::PID_SLEEP) begin
        next_state = locmd_pkg::LOCMD_DATA;
        next_is_sleep = 1'b1;
      end else begin
        next_state = locmd_pkg::LOCMD_IDLE;
      end
    end else if (rx_valid_i) begin
      case (state)
        locmd_pkg::LOCMD_IDLE: begin
          next_state = locmd_pkg::LOCMD_IDLE;
        end
        locmd_pkg::LOCMD_DATA: begin
          next_fields_ok = fields_ok & field_ok(is_sleep, idx, rx_byte_i, node_addr_i);
          if (!is_sleep && (idx == locmd_pkg::IDX_PTR)) begin
            next_ptr = rx_byte_i[locmd_pkg::PTR_W-1:0];
          end
          if (!is_sleep && (idx == locmd_pkg::IDX_VAL)) begin
            next_val = rx_byte_i;
          end
          next_idx = idx + 4'h1;
          if (idx == frame_len(is_sleep) - 4'h1) begin
            next_state = locmd_pkg::LOCMD_CSUM;
          end
        end
        locmd_pkg::LOCMD_CSUM: begin
          next_state = locmd_pkg::LOCMD_IDLE;
          if (rx_byte_i != ~run_sum) begin
            next_csum_err = 1'b1;
          end else if (fields_ok) begin
            if (is_sleep) begin
              next_sleep = 1'b1;
            end else begin
              next_otp_wr = 1'b1;
              next_otp_addr = ptr;
              next_otp_data = val;
            end
          end
        end
        default: begin
          next_state = locmd_pkg::LOCMD_IDLE;
        end
      endcase
    end
  end

  // Register the frame state and the outputs
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state <= locmd_pkg::LOCMD_IDLE;
      is_sleep <= 1'b0;
      idx <= 4'h0;
      fields_ok <= 1'b0;
      ptr <= 4'h0;
      val <= 8'h00;
      otp_wr <= 1'b0;
      otp_addr <= 4'h0;
      otp_data <= 8'h00;
      sleep <= 1'b0;
      csum_err <= 1'b0;
    end else begin
      state <= next_state;
      is_sleep <= next_is_sleep;
      idx <= next_idx;
      fields_ok <= next_fields_ok;
      ptr <= next_ptr;
      val <= next_val;
      otp_wr <= next_otp_wr;
      otp_addr <= next_otp_addr;
      otp_data <= next_otp_data;
      sleep <= next_sleep;
      csum_err <= next_csum_err;
    end
  end

  // Outputs straight from flip-flops
  assign otp_wr_o = otp_wr;
  assign otp_addr_o = otp_addr;
  assign otp_data_o = otp_data;
  assign sleep_o = sleep;
  assign csum_err_o = csum_err;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  // A write strobe lasts a single cycle
  property p_wr_single;
    @(posedge ref_clk_i) disable iff (!rst_n_i) otp_wr_o |=> !otp_wr_o;
  endproperty
  a_wr_single: assert property (p_wr_single) else $error("otp write longer than one cycle");

  // A write follows only a checked, matching OTP frame
  property p_wr_cause;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      otp_wr_o |-> ($past(state) == locmd_pkg::LOCMD_CSUM) && !$past(is_sleep) && $past(fields_ok);
  endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("otp write without valid frame");

  // The write goes to the pointer carried by the frame
  property p_wr_addr;
    @(posedge ref_clk_i) disable iff (!rst_n_i) otp_wr_o |-> (otp_addr_o == $past(ptr));
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("otp write address differs from pointer");

  // Checksum stage is reached after exactly the frame's data bytes
  property p_len;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (state == locmd_pkg::LOCMD_CSUM) && ($past(state) == locmd_pkg::LOCMD_DATA) |-> (idx == frame_len(is_sleep));
  endproperty
  a_len: assert property (p_len) else $error("data byte count wrong at checksum");

  // A checksum error has no effect
  property p_err_quiet;
    @(posedge ref_clk_i) disable iff (!rst_n_i) csum_err_o |-> !otp_wr_o && $stable(sleep_o);
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("frame acted on despite checksum error");

  // Sleep holds once entered
  property p_sleep_hold;
    @(posedge ref_clk_i) disable iff (!rst_n_i) sleep_o |=> sleep_o;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep dropped without reset");

  // Sleep only after a sleep frame with the right pattern
  property p_sleep_cause;
    @(posedge ref_clk_i) disable iff (!rst_n_i) $rose(sleep_o) |-> $past(is_sleep) && $past(fields_ok);
  endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("sleep without valid sleep frame");

  // Main scenarios
  c_otp_write: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) otp_wr_o);
  c_sleep: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(sleep_o));
  c_csum_err: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) csum_err_o);
endmodule
`default_nettype wire

// file: locmd_master.sv
// LIN master model: pid, data bytes, checksum
// Assumes the decoder samples on the rising edge
`timescale 1ns/1ps
`default_nettype none
module locmd_master (
  // Byte stream
  input wire logic clk_i,
  output logic pid_o = 1'b0,
  output logic vld_o = 1'b0,
  output logic [7:0] byte_o = 8'h00
);
  // One frame; bad flips checksum bits
  task automatic send(input logic [7:0] p, input logic [7:0] q[$], input logic [7:0] bad);
    logic [8:0] s = 9'h000;
    @(posedge clk_i) {pid_o, byte_o} <= {1'b1, p};
    foreach (q[i]) begin
      @(posedge clk_i) {pid_o, vld_o, byte_o} <= {2'b01, q[i]};
      s = s[7:0] + q[i];
      s = s[7:0] + s[8];
    end
    @(posedge clk_i) byte_o <= ~s[7:0] ^ bad;
    @(posedge clk_i) {vld_o, byte_o} <= {1'b0, ~byte_o};
  endtask
endmodule
`default_nettype wire

// file: locmd_top_bench.sv
// Bench for the OTP-write and sleep decoder
// Assumes byte-level frames from the master model
`timescale 1ns/1ps
`default_nettype none
module locmd_top_bench;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, p, v, w, sl, e, se;
  logic [7:0] b, d, q[$];
  logic [3:0] a;
  logic [11:0] wd;
  int n_mismatch = 0, checked = 0, nw;
  initial forever #2 ref_clk_i = ~ref_clk_i;
  locmd_master u_locmd_master (.clk_i(ref_clk_i), .pid_o(p), .vld_o(v), .byte_o(b));
  locmd_top u_locmd_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pid_valid_i(p), .rx_byte_i(b), .rx_valid_i(v),
    .frame_abort_i(1'b0), .node_addr_i(6'h15), .otp_wr_o(w), .otp_addr_o(a), .otp_data_o(d), .sleep_o(sl),
    .csum_err_o(e));
  // Count writes, latch error
  always @(posedge ref_clk_i) begin
    if (w === 1'b1) {nw, wd} <= {nw + 1, a, d};
    se <= se | (e === 1'b1);
  end
  task chk(string n, logic [11:0] g, x);
    checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, x, g);
    end
  endtask
  task run(logic [7:0] pi, logic [7:0] bad, logic [2:0] x);
    #1 nw = 0;
    se = 1'b0;
    u_locmd_master.send(pi, q, bad);
    repeat (12) @(posedge ref_clk_i);
    chk("wr_err_sleep", {9'h000, nw[0], se, sl}, {9'h000, x});
  endtask
  // Matching OTP frame writes its byte
  task otp_write;
    q = '{8'hD5, 8'hFF, 8'hFA, 8'h5C};
    run(8'hE7, 8'h00, 3'h4);
    chk("otp", wd, 12'hA5C);
  endtask
  // Broken checksum is rejected
  task bad_csum;
    run(8'hE7, 8'h01, 3'h2);
  endtask
  // Foreign node number is ignored
  task wrong_node;
    q[0] = 8'hD4;
    run(8'hE7, 8'h00, 3'h0);
  endtask
  // Sleep frame with a wrong byte is ignored
  task bad_sleep;
    q = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFE};
    run(8'h3C, 8'h00, 3'h0);
  endtask
  // Proper sleep frame enters sleep
  task good_sleep;
    q = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    run(8'h3C, 8'h00, 3'h1);
  endtask
  task final_report;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    otp_write;
    bad_csum;
    wrong_node;
    bad_sleep;
    good_sleep;
    final_report;
  end
  // Watchdog
  initial begin
    #4000 n_mismatch++;
    final_report;
  end
endmodule
`default_nettype wire
